//--- rtl/tcie_pkg.sv
// Constants, register map and decode helpers for the timer channel interrupt enable block.
// Assumes one clock domain shared with the channel flag logic and the bus.
package tcie_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int          NUM_CH      = 6;
    localparam int          EN_W        = 8;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0]  ADDR_EN0    = 8'h00;
    localparam logic [7:0]  ADDR_STAT   = 8'h18;
    localparam logic [7:0]  ADDR_MASK   = 8'h1c;

    // ------------------------------------------------------------------
    // Enable register fields
    // ------------------------------------------------------------------
    localparam int          BIT_CONV    = 7;
    localparam int          BIT_ONE     = 6;
    localparam int          BIT_UNF     = 5;
    localparam int          BIT_OVF     = 4;
    localparam int          BIT_D       = 3;
    localparam int          BIT_C       = 2;
    localparam int          BIT_B       = 1;
    localparam int          BIT_A       = 0;
    localparam logic [7:0]  EN_RESET    = 8'h40;
    localparam logic [7:0]  EN_RD_ONES  = 8'h40;
    localparam logic [7:0]  WMASK_CD    = 8'h9f;
    localparam logic [7:0]  WMASK_UNF   = 8'hb3;

    // ------------------------------------------------------------------
    // Bus answers and decode codes
    // ------------------------------------------------------------------
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_DECERR = 2'h3;
    localparam logic [3:0]  SEL_STAT    = 4'h6;
    localparam logic [3:0]  SEL_MASK    = 4'h7;
    localparam logic [3:0]  SEL_NONE    = 4'hf;

    // Channels with registers C and D; the others have underflow instead
    function automatic logic has_cd(input logic [2:0] ch);
        return (ch == 3'h0) || (ch == 3'h3);
    endfunction : has_cd

    function automatic logic [7:0] wmask(input logic [2:0] ch);
        return has_cd(ch) ? WMASK_CD : WMASK_UNF;
    endfunction : wmask

    // Address to register code; low two bits ignored, word aligned
    function automatic logic [3:0] reg_sel(input logic [7:0] addr);
        logic [7:0] a;
        a = {addr[7:2], 2'h0};
        if (a == ADDR_STAT)
            return SEL_STAT;
        else if (a == ADDR_MASK)
            return SEL_MASK;
        else if (a < ADDR_STAT)
            return a[5:2] - ADDR_EN0[5:2];
        else
            return SEL_NONE;
    endfunction : reg_sel

endpackage : tcie_pkg

//--- rtl/tcie_chan.sv
// Request gating of one timer channel: each flag ANDed with its enable bit.
// Assumes the enable byte already has its reserved bits cleared.
module tcie_chan #(
    parameter logic HAS_CD = 1'b1
) (
    // Enable and flags
    input  wire logic [7:0] enable,
    input  wire logic       flag_a,
    input  wire logic       flag_b,
    input  wire logic       flag_c,
    input  wire logic       flag_d,
    input  wire logic       flag_ovf,
    input  wire logic       flag_unf,
    // Gated requests
    output logic            req_a,
    output logic            req_b,
    output logic            req_c,
    output logic            req_d,
    output logic            req_ovf,
    output logic            req_unf
);

    // ------------------------------------------------------------------
    // Gating
    // ------------------------------------------------------------------
    assign req_a   = flag_a & enable[tcie_pkg::BIT_A];
    assign req_b   = flag_b & enable[tcie_pkg::BIT_B];
    // Overflow flag arrives already set by the counter wrap upstream
    assign req_ovf = flag_ovf & enable[tcie_pkg::BIT_OVF];
    assign req_c   = HAS_CD & flag_c & enable[tcie_pkg::BIT_C];
    assign req_d   = HAS_CD & flag_d & enable[tcie_pkg::BIT_D];
    assign req_unf = ~HAS_CD & flag_unf & enable[tcie_pkg::BIT_UNF];

endmodule : tcie_chan

//--- rtl/tcie_top.sv
// Six channel interrupt enable registers of a timer unit, with an AXI4-Lite slave,
// registered request outputs, converter start line and a summary interrupt.
// Assumes the flag register and counters sit outside on the same clock.
//
// Function
// - Six enable registers, one per channel
// - Bit 6 reads one, writes ignored
// - Bit 7 lets A events start converter
// - Bit 5 gates underflow in channels 1,2,4,5
// - Bit 5 reserved zero in channels 0,3
// - Bit 4 gates overflow in all channels
// - Bit 3 gates register D in 0,3
// - Bit 3 reserved zero in 1,2,4,5
// - Bit 2 gates register C in 0,3
// - Bit 2 reserved zero in 1,2,4,5
// - Bit 1 gates register B everywhere
// - Bit 0 gates register A everywhere
// - Overflow flag set on counter wrap
// - Flag clear after read withdraws request
module tcie_top (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Channel status flags, one bit per channel
    input  wire logic [5:0]  compare_a_flag,
    input  wire logic [5:0]  compare_b_flag,
    input  wire logic [5:0]  compare_c_flag,
    input  wire logic [5:0]  compare_d_flag,
    input  wire logic [5:0]  overflow_flag,
    input  wire logic [5:0]  underflow_flag,
    // Register A capture or compare match pulses
    input  wire logic [5:0]  compare_a_match,
    // Interrupt requests, one bit per channel
    output logic [5:0]       compare_a_irq_request,
    output logic [5:0]       compare_b_irq_request,
    output logic [5:0]       compare_c_irq_request,
    output logic [5:0]       compare_d_irq_request,
    output logic [5:0]       overflow_irq_request,
    output logic [5:0]       underflow_irq_request,
    // Converter start and summary interrupt
    output logic             converter_start,
    output logic             irq
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [5:0][7:0] en;
        logic [5:0]      stat;
        logic [5:0]      mask;
        logic            aw_got;
        logic            w_got;
        logic [7:0]      awaddr;
        logic [7:0]      wdata;
        logic            wstrb0;
        logic            awready;
        logic            wready;
        logic            bvalid;
        logic [1:0]      bresp;
        logic            arready;
        logic            rvalid;
        logic [1:0]      rresp;
        logic [31:0]     rdata;
        logic [5:0]      req_a;
        logic [5:0]      req_b;
        logic [5:0]      req_c;
        logic [5:0]      req_d;
        logic [5:0]      req_ovf;
        logic [5:0]      req_unf;
        logic            conv;
        logic            irq;
    } tcie_state_t;

    tcie_state_t state_q;
    tcie_state_t state_d;

    logic [5:0]  g_a;
    logic [5:0]  g_b;
    logic [5:0]  g_c;
    logic [5:0]  g_d;
    logic [5:0]  g_ovf;
    logic [5:0]  g_unf;
    logic [5:0]  conv_en;
    logic [5:0]  any_req;

    // ------------------------------------------------------------------
    // Per channel gating
    // ------------------------------------------------------------------
    // Each copy sees only its own enable byte and its own flags
    for (genvar ch = 0; ch < tcie_pkg::NUM_CH; ch++)
    begin : g_chan
        tcie_chan #(
            .HAS_CD   (tcie_pkg::has_cd(3'(ch)))
        ) u_chan (
            .enable   (state_q.en[ch]),
            .flag_a   (compare_a_flag[ch]),
            .flag_b   (compare_b_flag[ch]),
            .flag_c   (compare_c_flag[ch]),
            .flag_d   (compare_d_flag[ch]),
            .flag_ovf (overflow_flag[ch]),
            .flag_unf (underflow_flag[ch]),
            .req_a    (g_a[ch]),
            .req_b    (g_b[ch]),
            .req_c    (g_c[ch]),
            .req_d    (g_d[ch]),
            .req_ovf  (g_ovf[ch]),
            .req_unf  (g_unf[ch])
        );
        assign conv_en[ch] = state_q.en[ch][tcie_pkg::BIT_CONV];
        assign any_req[ch] = g_a[ch] | g_b[ch] | g_c[ch] | g_d[ch] | g_ovf[ch] | g_unf[ch];
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        logic [3:0] wsel;
        logic [3:0] rsel;
        logic [5:0] clr;
        wsel    = tcie_pkg::SEL_NONE;
        rsel    = tcie_pkg::SEL_NONE;
        clr     = 6'h00;
        state_d = state_q;

        // Address and data may arrive in either order
        if (s_axi_awvalid && state_q.awready)
        begin
            state_d.aw_got = 1'b1;
            state_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && state_q.wready)
        begin
            state_d.w_got  = 1'b1;
            state_d.wdata  = s_axi_wdata[7:0];
            state_d.wstrb0 = s_axi_wstrb[0];
        end
        if (state_q.bvalid && s_axi_bready)
            state_d.bvalid = 1'b0;

        // Write once both halves are held and no answer is pending
        if (state_d.aw_got && state_d.w_got && !state_q.bvalid)
        begin
            wsel           = tcie_pkg::reg_sel(state_d.awaddr);
            state_d.aw_got = 1'b0;
            state_d.w_got  = 1'b0;
            state_d.bvalid = 1'b1;
            state_d.bresp  = tcie_pkg::RESP_OKAY;
            case (wsel)
                4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5:
                begin
                    // Reserved and read-only bits never stored
                    if (state_d.wstrb0)
                        state_d.en[wsel] = state_d.wdata & tcie_pkg::wmask(wsel[2:0]);
                end
                tcie_pkg::SEL_STAT:
                begin
                    if (state_d.wstrb0)
                        clr = state_d.wdata[5:0];
                end
                tcie_pkg::SEL_MASK:
                begin
                    if (state_d.wstrb0)
                        state_d.mask = state_d.wdata[5:0];
                end
                default:
                    state_d.bresp = tcie_pkg::RESP_DECERR;
            endcase
        end

        // Read path
        if (state_q.rvalid && s_axi_rready)
            state_d.rvalid = 1'b0;
        if (s_axi_arvalid && state_q.arready)
        begin
            rsel           = tcie_pkg::reg_sel(s_axi_araddr);
            state_d.rvalid = 1'b1;
            state_d.rresp  = tcie_pkg::RESP_OKAY;
            state_d.rdata  = 32'h0000_0000;
            case (rsel)
                4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5:
                    state_d.rdata[7:0] = state_q.en[rsel] | tcie_pkg::EN_RD_ONES;
                tcie_pkg::SEL_STAT:
                    state_d.rdata[5:0] = state_q.stat;
                tcie_pkg::SEL_MASK:
                    state_d.rdata[5:0] = state_q.mask;
                default:
                    state_d.rresp = tcie_pkg::RESP_DECERR;
            endcase
        end

        // Readies follow the held state, so they are registered too
        state_d.arready = !state_d.rvalid;
        state_d.awready = !state_d.aw_got && !state_d.bvalid;
        state_d.wready  = !state_d.w_got && !state_d.bvalid;

        // Levels follow flag and enable; a cleared flag drops its request
        state_d.req_a   = g_a;
        state_d.req_b   = g_b;
        state_d.req_c   = g_c;
        state_d.req_d   = g_d;
        state_d.req_ovf = g_ovf;
        state_d.req_unf = g_unf;

        // One-cycle start pulse in any cycle with an enabled register A event, however many channels match
        state_d.conv    = |(compare_a_match & conv_en);

        // Sticky status; a request in the clearing cycle wins
        state_d.stat    = (state_q.stat & ~clr) | any_req;
        state_d.irq     = |(state_d.stat & state_d.mask);

        if (!aresetn)
        begin
            state_d = '0;
            for (int ch = 0; ch < tcie_pkg::NUM_CH; ch++)
                state_d.en[ch] = tcie_pkg::EN_RESET & tcie_pkg::wmask(3'(ch));
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        state_q <= state_d;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign s_axi_awready         = state_q.awready;
    assign s_axi_wready          = state_q.wready;
    assign s_axi_bvalid          = state_q.bvalid;
    assign s_axi_bresp           = state_q.bresp;
    assign s_axi_arready         = state_q.arready;
    assign s_axi_rvalid          = state_q.rvalid;
    assign s_axi_rresp           = state_q.rresp;
    assign s_axi_rdata           = state_q.rdata;
    assign compare_a_irq_request = state_q.req_a;
    assign compare_b_irq_request = state_q.req_b;
    assign compare_c_irq_request = state_q.req_c;
    assign compare_d_irq_request = state_q.req_d;
    assign overflow_irq_request  = state_q.req_ovf;
    assign underflow_irq_request = state_q.req_unf;
    assign converter_start       = state_q.conv;
    assign irq                   = state_q.irq;

endmodule : tcie_top

//--- dv/tcie_assertions.sv
// Checker on the request and converter start outputs of tcie_top.
// Assumes one clock, synchronous active-low reset.
module tcie_assertions (
    // Clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // Flags and match pulses
    input wire logic [5:0] compare_a_flag,
    input wire logic [5:0] compare_b_flag,
    input wire logic [5:0] compare_c_flag,
    input wire logic [5:0] compare_d_flag,
    input wire logic [5:0] overflow_flag,
    input wire logic [5:0] underflow_flag,
    input wire logic [5:0] compare_a_match,
    // Requests
    input wire logic [5:0] compare_a_irq_request,
    input wire logic [5:0] compare_b_irq_request,
    input wire logic [5:0] compare_c_irq_request,
    input wire logic [5:0] compare_d_irq_request,
    input wire logic [5:0] overflow_irq_request,
    input wire logic [5:0] underflow_irq_request,
    input wire logic       converter_start
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Start needs a match one edge earlier
    sequence conv_cause_s;
        $past(|compare_a_match);
    endsequence
    req_a_gate_a: assert property ((compare_a_irq_request & ~$past(compare_a_flag)) == 6'h00)
        else $error("request A without flag");
    req_b_gate_a: assert property ((compare_b_irq_request & ~$past(compare_b_flag)) == 6'h00)
        else $error("request B without flag");
    req_c_gate_a: assert property ((compare_c_irq_request & ~$past(compare_c_flag)) == 6'h00)
        else $error("request C without flag");
    req_d_gate_a: assert property ((compare_d_irq_request & ~$past(compare_d_flag)) == 6'h00)
        else $error("request D without flag");
    ovf_gate_a: assert property ((overflow_irq_request & ~$past(overflow_flag)) == 6'h00)
        else $error("overflow request without flag");
    unf_gate_a: assert property ((underflow_irq_request & ~$past(underflow_flag)) == 6'h00)
        else $error("underflow request without flag");
    unf_reserved_a: assert property ((underflow_irq_request & 6'h09) == 6'h00)
        else $error("underflow request on channel 0 or 3");
    cd_reserved_a: assert property (((compare_c_irq_request | compare_d_irq_request) & 6'h36) == 6'h00)
        else $error("C or D request on channel without them");
    conv_cause_a: assert property (converter_start |-> conv_cause_s)
        else $error("converter start without match");
endmodule : tcie_assertions

bind tcie_top tcie_assertions u_chk (.aclk, .aresetn, .compare_a_flag, .compare_b_flag, .compare_c_flag,
    .compare_d_flag, .overflow_flag, .underflow_flag, .compare_a_match, .compare_a_irq_request,
    .compare_b_irq_request, .compare_c_irq_request, .compare_d_irq_request, .overflow_irq_request,
    .underflow_irq_request, .converter_start);

//--- dv/tcie_top_tb.sv
// Self-checking bench for tcie_top over AXI4-Lite.
// Assumes the flag inputs are driven here in place of the flag register.
module tcie_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        aclk, aresetn, conv, irq;
    logic        awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, got;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rsp;
    logic [5:0]  fa, fb, fc, fd, fo, fu, am, ra, rb, rc, rd, ro, ru;
    int          mismatches, checked, cycles;
    // Valid channels per request kind, slot order matches enable bits
    localparam logic [35:0] VM = {6'h36, 6'h3f, 6'h09, 6'h09, 6'h3f, 6'h3f};

    tcie_top dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .compare_a_flag(fa), .compare_b_flag(fb), .compare_c_flag(fc), .compare_d_flag(fd),
        .overflow_flag(fo), .underflow_flag(fu), .compare_a_match(am),
        .compare_a_irq_request(ra), .compare_b_irq_request(rb), .compare_c_irq_request(rc),
        .compare_d_irq_request(rd), .overflow_irq_request(ro), .underflow_irq_request(ru),
        .converter_start(conv), .irq(irq));

    // ------------------------------------------------------------------
    // Clock, timeout and checks
    // ------------------------------------------------------------------
    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // A hung handshake ends the run here instead of in each wait
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_of_test

    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e)
        begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk_word

    task automatic chk_req(input logic [35:0] e);
        checked++;
        if ({ru, ro, rd, rc, rb, ra} !== e)
        begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, {ru, ro, rd, rc, rb, ra}, e);
        end
    endtask : chk_req

    // ------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        do
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
        end while (!bvalid);
        rsp = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
        end while (!rvalid);
        {got, rsp} = {rdata, rresp};
        rready <= 1'b0;
        chk_word(got, e);
    endtask : rd_chk

    task automatic wait_cy(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask : wait_cy

    task automatic pulse(input logic [5:0] m, input logic e);
        @(posedge aclk);
        am <= m;
        @(posedge aclk);
        am <= 6'h00;
        #1;
        chk_word({31'h0, conv}, {31'h0, e});
    endtask : pulse

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
        {fa, fb, fc, fd, fo, fu, am, mismatches, checked, cycles} = '0;
        wstrb = 4'hf;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        for (int c = 0; c < 6; c++)
            rd_chk(8'(c * 4), 32'h40);
        rd_chk(8'h20, 32'h0);
        chk_word({30'h0, rsp}, {30'h0, tcie_pkg::RESP_DECERR});
        wr(8'h20, 32'hff);
        chk_word({30'h0, rsp}, {30'h0, tcie_pkg::RESP_DECERR});
        for (int c = 0; c < 6; c++)
        begin
            wr(8'(c * 4), 32'hff);
            chk_word({30'h0, rsp}, {30'h0, tcie_pkg::RESP_OKAY});
            rd_chk(8'(c * 4), (c == 0 || c == 3) ? 32'hdf : 32'hf3);
            wr(8'(c * 4), 32'h00);
            rd_chk(8'(c * 4), 32'h40);
        end
        $display("test register access done");
        {fa, fb, fc, fd, fo, fu} <= '1;
        for (int b = 0; b < 6; b++)
        begin
            for (int c = 0; c < 6; c++)
                wr(8'(c * 4), 32'h1 << b);
            wait_cy(3);
            chk_req(VM & (36'h3f << (6 * b)));
        end
        for (int c = 0; c < 6; c++)
            wr(8'(c * 4), 32'h3f);
        wait_cy(3);
        chk_req(VM);
        wr(8'h10, 32'h00);
        wait_cy(3);
        chk_req(VM & ~{6{6'h10}});
        @(posedge aclk);
        {fa, fb, fc, fd, fo, fu} <= '0;
        wait_cy(2);
        chk_req(36'h0);
        $display("test gating done");
        wr(8'h08, 32'h80);
        pulse(6'h04, 1'b1);
        pulse(6'h02, 1'b0);
        pulse(6'h3f, 1'b1);
        $display("test converter start done");
        wr(8'h08, 32'h3f);
        wr(8'h1c, 32'h04);
        // Gating test left every status bit set
        wr(8'h18, 32'h3f);
        rd_chk(8'h18, 32'h00);
        chk_word({31'h0, irq}, 32'h0);
        @(posedge aclk);
        fo <= 6'h06;
        wait_cy(3);
        chk_word({31'h0, irq}, 32'h1);
        rd_chk(8'h18, 32'h06);
        @(posedge aclk);
        fo <= 6'h00;
        wr(8'h18, 32'h04);
        wait_cy(2);
        chk_word({31'h0, irq}, 32'h0);
        rd_chk(8'h18, 32'h02);
        wr(8'h18, 32'h02);
        rd_chk(8'h18, 32'h00);
        $display("test interrupt done");
        end_of_test();
    end
endmodule : tcie_top_tb
